// ---- include/fwec_pkg.sv ----
/*
 * Constants, register map and state type of the flash write/erase controller.
 * Assumes a 100 MHz APB clock; register indices are word indices on APB.
 */
package fwec_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_FWT     = 8'hAB;
    localparam logic [7:0] IDX_ADDR_LO = 8'hAC;
    localparam logic [7:0] IDX_ADDR_HI = 8'hAD;
    localparam logic [7:0] IDX_CTRL    = 8'hAE;
    localparam logic [7:0] IDX_WDATA   = 8'hAF;

    // ------------------------------------------------------------
    // Control fields and reset values
    // ------------------------------------------------------------
    localparam int CTRL_BUSY_BIT   = 7;
    localparam int CTRL_PEND_BIT   = 6;
    localparam int CTRL_SPARE5_BIT = 5;
    localparam int CTRL_CONTINUOUS_READ_ENABLE_BIT = 4;
    localparam int CTRL_WRITE_BIT  = 1;
    localparam int CTRL_ERASE_BIT  = 0;
    localparam logic [7:0] CTRL_RESET  = 8'h00;
    localparam logic [7:0] ADDR_RESET  = 8'h00;
    localparam logic [7:0] WDATA_RESET = 8'h00;
    localparam logic [7:0] FWT_RESET   = 8'h2A;
    localparam logic [7:0] FWT_16MHZ   = 8'h15;
    localparam logic [4:0] DMA_TRIGGER_SELECT_SEL = 5'h12;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 10;
    localparam int TIMEOUT_US     = 40;
    localparam int PROG_TIME_US   = 20;
    localparam int ERASE_TIME_MS  = 20;
    localparam int TIMEOUT_CYCLES = TIMEOUT_US * 1000 / CLK_PERIOD_NS;
    localparam int PROG_CYCLES    = (PROG_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ERASE_CYCLES   = (ERASE_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_W        = 22;

    typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_COLLECT, ST_PROGRAM} fwec_state_e;

endpackage

// ---- src/fwec_top.sv ----
/*
 * Flash write/erase sequencer with APB register access, DMA pacing trigger,
 * per-word timeout and a timing generator scaled by the timing setting.
 * Assumes the flash macro, DMA and CPU share pclk; the flash macro returns
 * the currently stored word on flash_rdata for the word on flash_addr.
 */
`timescale 1ns/1ps

// Operation
// RL1: DMA channel picks the flash trigger with select code 10010.
// RL2: Pulse DMA trigger whenever the data port can take another byte.
// RL3: DMA does single byte transfers to fixed data port, length multiple of 4.
// RL4: A DMA write stalled over 40 us drops write and abandons it.
// RL5: Setting write start with DMA armed raises the first trigger.
// RL6: Flash-resident code setting write start sits on a 4-byte aligned address.
// RL7: Program one word each time four bytes arrive while writing.
// RL8: CPU polls word pending and feeds next four bytes once it is low.
// RL9: Four bytes of a word must arrive within 40 us.
// RL10: Word timeout ends the write and clears busy, keeping the address.
// RL11: Erase bit erases the page chosen by address high bits 6:1.
// RL12: An erased page reads as all ones.
// RL13: Erase and write set together: erase first, then write.
// RL14: Control bit 7 reads 1 while writing or erasing.
// RL15: A page erase lasts 20 ms.
// RL16: Fetch stalls while an operation started from flash code runs.
// RL17: Flash code setting erase must follow with a no-operation.
// RL18: Timing generator scaled by six-bit setting, reset 0x2A.
// RL19: Software loads 0x15 for 16 MHz and 0x2A for 32 MHz.
// RL20: Control bit 6 reads 1 while the current word programs.
// RL21: Control bit 4 keeps flash read enables on continuously.
// RL22: Write start and erase bits always read back as 0.
// RL23: Word target is the 15-bit address from high and low registers.
// RL24: First byte written becomes the word's least significant byte.
// RL25: Programming only clears bits; ones are never restored.
module fwec_top #(
    parameter int ERASE_CYCLES = fwec_pkg::ERASE_CYCLES
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // DMA pacing
    output logic             dma_trigger,
    // CPU fetch
    input  wire logic        op_from_flash,
    output logic             fetch_stall,
    // Flash array
    input  wire logic        flash_read_req,
    input  wire logic [31:0] flash_rdata,
    output logic             flash_read_en,
    output logic             flash_prog,
    output logic             flash_erase,
    output logic      [14:0] flash_addr,
    output logic      [31:0] flash_wdata,
    output logic      [5:0]  flash_page
);

    localparam int TW = fwec_pkg::TIMER_W;
    localparam int FWT_DIV = int'(fwec_pkg::FWT_RESET);
    localparam logic [TW-1:0] PROG_TICKS  = TW'((fwec_pkg::PROG_CYCLES + FWT_DIV - 1) / FWT_DIV);
    localparam logic [TW-1:0] ERASE_TICKS = TW'((ERASE_CYCLES + FWT_DIV - 1) / FWT_DIV);
    localparam logic [TW-1:0] TOUT_CYC    = TW'(fwec_pkg::TIMEOUT_CYCLES);

    typedef struct packed {
        fwec_pkg::fwec_state_e state;
        logic [2:0]    spare;
        logic          continuous_read_enable;
        logic [7:0]    addr_hi;
        logic [7:0]    addr_lo;
        logic [7:0]    program_timing_setting;
        logic [7:0]    wdata;
        logic [31:0]   word;
        logic [1:0]    nbytes;
        logic          pend_write;
        logic          from_flash;
        logic [TW-1:0] timer;
        logic [5:0]    presc;
        logic          pready;
        logic          pslverr;
        logic [31:0]   prdata;
        logic          dma_trigger_select;
        logic          f_prog;
        logic          f_erase;
        logic [14:0]   f_addr;
        logic [31:0]   f_wdata;
        logic [5:0]    f_page;
        logic          read_en;
        logic          stall;
    } fwec_state_s;

    fwec_state_s s;
    fwec_state_s next_s;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic [7:0]  idx;
    logic        hit;
    logic        acc;
    logic        wr;
    logic        wr_ctrl;
    logic        wr_byte;
    logic        tick;
    logic        busy;
    logic        pend;
    logic [7:0]  ctrl_rd;
    logic [31:0] rd_val;
    logic [14:0] waddr;
    logic [31:0] new_word;

    assign idx      = paddr[9:2];
    assign hit      = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0)
                      && (idx >= fwec_pkg::IDX_FWT) && (idx <= fwec_pkg::IDX_WDATA);
    assign acc      = psel && penable;
    assign wr       = acc && s.pready && pwrite && hit;
    assign wr_ctrl  = wr && (idx == fwec_pkg::IDX_CTRL);
    assign wr_byte  = wr && (idx == fwec_pkg::IDX_WDATA);
    assign tick     = (s.presc == 6'h00);
    assign busy     = (s.state != fwec_pkg::ST_IDLE);
    assign pend     = (s.state == fwec_pkg::ST_PROGRAM);
    assign waddr    = {s.addr_hi[6:0], s.addr_lo};
    assign new_word = {pwdata[7:0], s.word[31:8]};

    always_comb begin
        ctrl_rd = {busy, pend, s.spare[2], s.continuous_read_enable, s.spare[1:0], 2'h0}; // RL14 RL20 RL22
        unique case (idx)
            fwec_pkg::IDX_FWT:     rd_val = {24'h0, s.program_timing_setting};
            fwec_pkg::IDX_ADDR_LO: rd_val = {24'h0, s.addr_lo};
            fwec_pkg::IDX_ADDR_HI: rd_val = {24'h0, s.addr_hi};
            fwec_pkg::IDX_CTRL:    rd_val = {24'h0, ctrl_rd};
            fwec_pkg::IDX_WDATA:   rd_val = {24'h0, s.wdata};
            default:               rd_val = 32'h0;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_s          = s;
        next_s.dma_trigger_select = 1'b0;
        next_s.pready   = acc && !s.pready;
        next_s.pslverr  = 1'b0;
        next_s.prdata   = 32'h0;
        if (acc && !s.pready) begin
            next_s.pslverr = !hit;
            next_s.prdata  = hit ? rd_val : 32'h0;
        end
        // One timing unit per setting count; zero behaves as one
        if (tick) begin
            next_s.presc = (s.program_timing_setting[5:0] == 6'h00) ? 6'h00 : s.program_timing_setting[5:0] - 6'h01; // RL18
        end else begin
            next_s.presc = s.presc - 6'h01;
        end
        next_s.read_en = s.continuous_read_enable || flash_read_req; // RL21

        unique case (s.state)
            fwec_pkg::ST_IDLE: begin
            end
            fwec_pkg::ST_ERASE: begin
                if (tick) begin
                    if (s.timer <= TW'(1)) begin // RL15
                        next_s.f_erase = 1'b0;
                        if (s.pend_write) begin // RL13
                            next_s.state    = fwec_pkg::ST_COLLECT;
                            next_s.timer    = TOUT_CYC;
                            next_s.nbytes   = 2'h0;
                            next_s.dma_trigger_select = 1'b1;
                        end else begin
                            next_s.state = fwec_pkg::ST_IDLE;
                        end
                    end else begin
                        next_s.timer = s.timer - TW'(1);
                    end
                end
            end
            fwec_pkg::ST_COLLECT: begin
                // Address is kept and the byte count cleared so software can retry the whole word
                if (s.timer <= TW'(1)) begin
                    next_s.state  = fwec_pkg::ST_IDLE; // RL4 RL9 RL10
                    next_s.nbytes = 2'h0;
                end else begin
                    next_s.timer = s.timer - TW'(1);
                end
            end
            fwec_pkg::ST_PROGRAM: begin
                if (tick) begin
                    if (s.timer <= TW'(1)) begin
                        next_s.f_prog   = 1'b0;
                        {next_s.addr_hi[6:0], next_s.addr_lo} = waddr + 15'h0001;
                        next_s.state    = fwec_pkg::ST_COLLECT;
                        next_s.timer    = TOUT_CYC;
                        next_s.nbytes   = 2'h0;
                        next_s.dma_trigger_select = 1'b1; // RL2
                    end else begin
                        next_s.timer = s.timer - TW'(1);
                    end
                end
            end
        endcase

        // ------------------------------------------------------------
        // Register writes
        // ------------------------------------------------------------
        if (wr) begin
            unique case (idx)
                fwec_pkg::IDX_FWT:     next_s.program_timing_setting     = pwdata[7:0];
                fwec_pkg::IDX_ADDR_LO: next_s.addr_lo = pwdata[7:0];
                fwec_pkg::IDX_ADDR_HI: next_s.addr_hi = pwdata[7:0];
                fwec_pkg::IDX_WDATA:   next_s.wdata   = pwdata[7:0];
                default: begin
                end
            endcase
        end
        if (wr_ctrl) begin
            next_s.continuous_read_enable = pwdata[fwec_pkg::CTRL_CONTINUOUS_READ_ENABLE_BIT];
            next_s.spare  = {pwdata[fwec_pkg::CTRL_SPARE5_BIT], pwdata[3:2]};
            // Starts while busy are ignored so a running erase is never cut short
            if (!busy && pwdata[fwec_pkg::CTRL_ERASE_BIT]) begin
                next_s.state      = fwec_pkg::ST_ERASE; // RL11
                next_s.f_erase    = 1'b1;
                // Prescaler restarts so the erase lasts a whole number of ticks
                next_s.presc      = (s.program_timing_setting[5:0] == 6'h00) ? 6'h00 : s.program_timing_setting[5:0] - 6'h01; // RL15 RL18
                next_s.f_page     = s.addr_hi[6:1]; // RL11 RL12
                next_s.timer      = ERASE_TICKS;
                next_s.pend_write = pwdata[fwec_pkg::CTRL_WRITE_BIT]; // RL13
                next_s.from_flash = op_from_flash;
            end else if (!busy && pwdata[fwec_pkg::CTRL_WRITE_BIT]) begin
                next_s.state      = fwec_pkg::ST_COLLECT;
                next_s.timer      = TOUT_CYC; // RL9
                next_s.nbytes     = 2'h0;
                next_s.dma_trigger_select   = 1'b1; // RL5
                next_s.pend_write = 1'b0;
                next_s.from_flash = op_from_flash;
            end
        end
        if (wr_byte && (s.state == fwec_pkg::ST_COLLECT)) begin
            next_s.word   = new_word; // RL24
            next_s.nbytes = s.nbytes + 2'h1;
            if (s.nbytes == 2'h3) begin
                next_s.state   = fwec_pkg::ST_PROGRAM; // RL7 RL20
                next_s.f_prog  = 1'b1;
                next_s.f_addr  = waddr; // RL23
                next_s.f_wdata = new_word & flash_rdata; // RL25
                next_s.timer   = PROG_TICKS;
                next_s.presc   = (s.program_timing_setting[5:0] == 6'h00) ? 6'h00 : s.program_timing_setting[5:0] - 6'h01; // RL18
            end else begin
                next_s.dma_trigger_select = 1'b1; // RL2
            end
        end
        // Target shown ahead of programming so the array returns the old word
        if (next_s.state != fwec_pkg::ST_PROGRAM) begin
            next_s.f_addr = {next_s.addr_hi[6:0], next_s.addr_lo}; // RL23 RL25
        end
        next_s.stall = (next_s.state != fwec_pkg::ST_IDLE) && next_s.from_flash; // RL16
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s       <= '0;
            s.program_timing_setting   <= fwec_pkg::FWT_RESET; // RL18
            s.presc <= 6'h00;
        end else begin
            s <= next_s;
        end
    end

    assign prdata        = s.prdata;
    assign pready        = s.pready;
    assign pslverr       = s.pslverr;
    assign dma_trigger   = s.dma_trigger_select; // RL1
    assign fetch_stall   = s.stall;
    assign flash_read_en = s.read_en;
    assign flash_prog    = s.f_prog;
    assign flash_erase   = s.f_erase;
    assign flash_addr    = s.f_addr;
    assign flash_wdata   = s.f_wdata;
    assign flash_page    = s.f_page;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_start_trigger_select;
        wr_ctrl && !busy && pwdata[1] && !pwdata[0] |=> dma_trigger && s.state == fwec_pkg::ST_COLLECT;
    endproperty
    a_start_trigger_select: assert property (p_start_trigger_select) else $error("No trigger on write start"); // RL5

    property p_fourth_byte;
        wr_byte && s.state == fwec_pkg::ST_COLLECT && s.nbytes == 2'h3 |=> flash_prog && !dma_trigger;
    endproperty
    a_fourth_byte: assert property (p_fourth_byte) else $error("Fourth byte did not program"); // RL7

    property p_mid_byte;
        wr_byte && s.state == fwec_pkg::ST_COLLECT && s.nbytes != 2'h3 |=> dma_trigger;
    endproperty
    a_mid_byte: assert property (p_mid_byte) else $error("No trigger after byte"); // RL2

    property p_timeout;
        s.state == fwec_pkg::ST_COLLECT && s.timer == TW'(1) && !wr_byte |=> !busy;
    endproperty
    a_timeout: assert property (p_timeout) else $error("Word timeout did not end write"); // RL10

    property p_wo_bits;
        pready && hit && idx == fwec_pkg::IDX_CTRL && !pwrite |-> prdata[1:0] == 2'h0;
    endproperty
    a_wo_bits: assert property (p_wo_bits) else $error("Start bits read nonzero"); // RL22

    property p_busy_read;
        acc && !s.pready && hit && idx == fwec_pkg::IDX_CTRL && !pwrite |=> prdata[7] == $past(busy)
            && prdata[6] == $past(pend);
    endproperty
    a_busy_read: assert property (p_busy_read) else $error("Status bits misreported"); // RL14

    property p_erase_then_write;
        s.state == fwec_pkg::ST_ERASE && next_s.state != fwec_pkg::ST_ERASE && s.pend_write
            |=> s.state == fwec_pkg::ST_COLLECT && dma_trigger && !flash_erase;
    endproperty
    a_erase_then_write: assert property (p_erase_then_write) else $error("Write not after erase"); // RL13

    property p_clear_only;
        $rose(flash_prog) |-> (flash_wdata & ~$past(flash_rdata)) == 32'h0;
    endproperty
    a_clear_only: assert property (p_clear_only) else $error("Program sets a cleared bit"); // RL25

    property p_page;
        $rose(flash_erase) |-> flash_page == $past(s.addr_hi[6:1]);
    endproperty
    a_page: assert property (p_page) else $error("Wrong erase page"); // RL11

    property p_read_en;
        ##1 flash_read_en == $past(s.continuous_read_enable || flash_read_req);
    endproperty
    a_read_en: assert property (p_read_en) else $error("Read enable mismatch"); // RL21

    c_cpu_word: cover property (wr_byte && s.nbytes == 2'h3 ##1 flash_prog);
    c_timeout: cover property (s.state == fwec_pkg::ST_COLLECT ##1 s.state == fwec_pkg::ST_IDLE);
    c_erase_write: cover property (s.state == fwec_pkg::ST_ERASE ##1 s.state == fwec_pkg::ST_COLLECT);

endmodule // fwec_top

// ---- tb/fwec_far_model.sv ----
/*
 * Far side of the controller: flash array storage and DMA trigger counter.
 * Assumes the controller's flash and trigger outputs share pclk.
 */
`timescale 1ns/1ps

module fwec_far_model (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Controller outputs
    input  wire logic        dma_trigger,
    input  wire logic        flash_prog,
    input  wire logic        flash_erase,
    input  wire logic [14:0] flash_addr,
    input  wire logic [31:0] flash_wdata,
    input  wire logic [5:0]  flash_page,
    // Model outputs
    output logic      [31:0] flash_rdata,
    output int               trigger_select_count,
    output int               erase_len
);
    // Channel listens to the flash source only
    localparam logic [4:0] TRIGGER_SELECT_SEL = 5'h12;

    logic [31:0] mem [0:32767];
    logic        prog_q;
    logic        erase_q;

    assign flash_rdata = mem[flash_addr];

    initial begin
        foreach (mem[i]) mem[i] = 32'hFFFF_FFFF;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trigger_select_count <= 0;
            erase_len  <= 0;
            prog_q     <= 1'b0;
            erase_q    <= 1'b0;
        end else begin
            prog_q  <= flash_prog;
            erase_q <= flash_erase;
            if (dma_trigger && TRIGGER_SELECT_SEL == fwec_pkg::DMA_TRIGGER_SELECT_SEL) trigger_select_count <= trigger_select_count + 1;
            if (flash_erase) erase_len <= erase_q ? erase_len + 1 : 1;
            // Programming can only clear bits
            if (flash_prog && !prog_q) mem[flash_addr] <= mem[flash_addr] & flash_wdata;
            if (erase_q && !flash_erase) begin
                for (int w = 0; w < 512; w++) mem[{flash_page, 9'(w)}] <= 32'hFFFF_FFFF;
            end
        end
    end
endmodule // fwec_far_model

// ---- tb/flash_write_erase_controller_bench.sv ----
/*
 * Self-checking bench of the flash write/erase controller over APB.
 * Assumes fwec_pkg and fwec_far_model are compiled first.
 */
`timescale 1ns/1ps

module flash_write_erase_controller_bench;
    logic pclk, presetn, psel, penable, pwrite, op_from_flash, flash_read_req, last_err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, flash_rdata, flash_wdata;
    logic pready, pslverr, dma_trigger, fetch_stall, flash_read_en, flash_prog, flash_erase;
    logic [14:0] flash_addr;
    logic [5:0]  flash_page;
    int          n_errors, total_checks, trigger_select_count, erase_len;
    logic [31:0] model [int];

    fwec_top #(.ERASE_CYCLES(420)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .dma_trigger(dma_trigger), .op_from_flash(op_from_flash), .fetch_stall(fetch_stall),
        .flash_read_req(flash_read_req), .flash_rdata(flash_rdata), .flash_read_en(flash_read_en),
        .flash_prog(flash_prog), .flash_erase(flash_erase), .flash_addr(flash_addr),
        .flash_wdata(flash_wdata), .flash_page(flash_page));

    fwec_far_model i_far (.pclk(pclk), .presetn(presetn), .dma_trigger(dma_trigger), .flash_prog(flash_prog),
        .flash_erase(flash_erase), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
        .flash_page(flash_page), .flash_rdata(flash_rdata), .trigger_select_count(trigger_select_count), .erase_len(erase_len));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [31:0] rd);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd       = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] x;
        apb(1'b1, idx, d, x);
    endtask

    task automatic rreg(input logic [7:0] idx, output logic [31:0] r);
        apb(1'b0, idx, 8'h00, r);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic write_word(input logic [31:0] w, input int nbytes);
        for (int i = 0; i < nbytes; i++) wreg(fwec_pkg::IDX_WDATA, w[8*i +: 8]);
    endtask

    function automatic logic [31:0] old_word(input int a);
        return model.exists(a) ? model[a] : 32'hFFFF_FFFF;
    endfunction

    task automatic results();
        $display("Checks %0d, mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Clock and watchdog
    // ------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Whole run needs about 13000 cycles
    initial begin
        repeat (40000) @(posedge pclk);
        n_errors++;
        $display("Error at %0t ns: run did not finish in time", $time);
        results();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        logic [31:0] r, w;
        int          a;
        {presetn, psel, penable, pwrite, op_from_flash, flash_read_req} = 6'b0;
        paddr  = 12'h000;
        pwdata = 32'h0;
        r = $urandom(32'h165563b7);
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rreg(fwec_pkg::IDX_FWT, r); chk(r, {24'h0, fwec_pkg::FWT_RESET}, "timing reset");
        rreg(fwec_pkg::IDX_CTRL, r); chk(r, {24'h0, fwec_pkg::CTRL_RESET}, "control reset");
        rreg(8'hB0, r); chk({r[30:0], last_err}, 32'h1, "unmapped access");
        wreg(fwec_pkg::IDX_FWT, fwec_pkg::FWT_16MHZ);
        rreg(fwec_pkg::IDX_FWT, r); chk(r, 32'h15, "timing readback");
        wreg(fwec_pkg::IDX_FWT, fwec_pkg::FWT_RESET);
        $display("registers test done");
        // Word over a partly programmed location
        a = 'h510;
        w = $urandom();
        i_far.mem[a] = 32'hF0F0_3C3C;
        model[a] = 32'hF0F0_3C3C;
        wreg(fwec_pkg::IDX_ADDR_LO, 8'h10);
        wreg(fwec_pkg::IDX_ADDR_HI, 8'h05);
        wreg(fwec_pkg::IDX_CTRL, 8'h02);
        rreg(fwec_pkg::IDX_CTRL, r); chk(r & 32'h83, 32'h80, "busy with start bits clear");
        write_word(w, 4);
        while (flash_prog !== 1'b1) @(posedge pclk);
        chk({17'h0, flash_addr}, a, "word address");
        chk(flash_wdata, w & old_word(a), "programmed word");
        model[a] = w & old_word(a);
        rreg(fwec_pkg::IDX_CTRL, r); chk(r & 32'h40, 32'h40, "word pending");
        while (flash_prog !== 1'b0) @(posedge pclk);
        repeat (3) @(posedge pclk);
        chk(32'(trigger_select_count), 32'd5, "trigger pulses");
        rreg(fwec_pkg::IDX_CTRL, r); chk(r & 32'h40, 32'h0, "word pending clear");
        $display("cpu write test done");
        // Partial word runs into the word timeout
        write_word($urandom(), 2);
        repeat (3800) @(posedge pclk);
        rreg(fwec_pkg::IDX_CTRL, r); chk(r & 32'h80, 32'h80, "busy before timeout");
        repeat (400) @(posedge pclk);
        rreg(fwec_pkg::IDX_CTRL, r); chk(r & 32'hC0, 32'h0, "idle after timeout");
        chk(32'(trigger_select_count), 32'd7, "no word after timeout");
        $display("timeout test done");
        // Erase and write together, started from flash code
        a = 'h511;
        op_from_flash <= 1'b1;
        wreg(fwec_pkg::IDX_CTRL, 8'h03);
        op_from_flash <= 1'b0;
        while (flash_erase !== 1'b1) @(posedge pclk);
        chk(fetch_stall, 32'h1, "fetch stalled");
        chk(flash_page, 32'h2, "erased page");
        while (flash_erase === 1'b1) @(posedge pclk);
        chk(32'(erase_len), 32'd420, "erase length");
        chk(32'(trigger_select_count), 32'd7, "no trigger during erase");
        foreach (model[k]) if ((k >> 9) == 2) model[k] = 32'hFFFF_FFFF;
        w = $urandom();
        repeat (2) @(posedge pclk);
        write_word(w, 4);
        while (flash_prog !== 1'b1) @(posedge pclk);
        chk({17'h0, flash_addr}, a, "address kept");
        chk(flash_wdata, w & old_word(a), "word after erase");
        while (flash_prog !== 1'b0) @(posedge pclk);
        repeat (4100) @(posedge pclk);
        chk(fetch_stall, 32'h0, "fetch resumed");
        $display("erase test done");
        // Read enable modes
        wreg(fwec_pkg::IDX_CTRL, 8'h10);
        repeat (2) @(posedge pclk);
        chk(flash_read_en, 32'h1, "continuous read");
        rreg(fwec_pkg::IDX_CTRL, r); chk(r, 32'h10, "control readback");
        wreg(fwec_pkg::IDX_CTRL, 8'h00);
        repeat (2) @(posedge pclk);
        chk(flash_read_en, 32'h0, "read on demand idle");
        flash_read_req <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(flash_read_en, 32'h1, "read on demand");
        flash_read_req <= 1'b0;
        $display("read enable test done");
        results();
    end
endmodule // flash_write_erase_controller_bench
